/* File: spbs_pkg.sv */
// constants and types for the serial port stop/baud/status block
`default_nettype none
package spbs_pkg;
    localparam logic [2:0] ADDR_STATUS   = 3'h0;
    localparam logic [2:0] ADDR_CTRL1    = 3'h1;
    localparam logic [2:0] ADDR_RELOAD   = 3'h2;
    localparam logic [2:0] ADDR_BUFFER   = 3'h3;
    localparam logic [2:0] ADDR_CTRL2    = 3'h4;
    localparam logic [2:0] ADDR_EVENTS   = 3'h5;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] CTRL1_RESET   = 8'h00;
    localparam logic [7:0] RELOAD_RESET  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // status bit positions
    localparam int ST_SAMPLE  = 7;
    localparam int ST_EDGE    = 6;
    localparam int ST_DATA    = 5;
    localparam int ST_STOP    = 4;
    localparam int ST_START   = 3;
    localparam int ST_DIR     = 2;
    localparam int ST_UPDATE  = 1;
    localparam int ST_FULL    = 0;
    // control one bit positions
    localparam int C1_WRITE_COLLISION_FLAG    = 7;
    localparam int C1_OVF     = 6;
    localparam int C1_EN      = 5;
    localparam int C1_CKREL   = 4;
    // control two (request) bit positions
    localparam int C2_ACK     = 4;
    localparam int C2_RCV     = 3;
    localparam int C2_STOP    = 2;
    localparam int C2_RESTART = 1;
    localparam int C2_START   = 0;
    // event register bit positions
    localparam int EV_BCOL    = 1;
    localparam int EV_PIRQ    = 0;
    localparam logic [3:0] MODE_I2C_MASTER  = 4'h8;
    localparam logic [3:0] MODE_I2C_FW      = 4'hB;
    localparam logic [3:0] MODE_SPI_MASTER  = 4'hA;
    localparam logic [7:0] RELOAD_MIN_I2C   = 8'h03;
    typedef enum logic [2:0] {
        SPBS_IDLE     = 3'b000,
        SPBS_SDA_LOW  = 3'b001,
        SPBS_SCL_REL  = 3'b010,
        SPBS_SCL_HIGH = 3'b011,
        SPBS_SDA_REL  = 3'b100,
        SPBS_DONE     = 3'b101
    } spbs_stop_t;
endpackage
`default_nettype wire

/* File: spbs_core.sv */
// serial port baud generator, stop collision check and status registers
//
// Contract
// (R1) stop: data still low after generator expiry flags collision
// (R2) stop: clock low after release, before data high, flags collision
// (R3) stop: drive data low, release clock, reload generator, count, sample
// (R4) master modes: buffer write starts generator counting
// (R5) after operation ends generator stops, clock pin keeps level
// (R6) generator reloads twice per serial clock period
// (R7) i2c master clock equals oscillator over four times reload plus one
// (R8) software never programs reload zero, one or two for i2c
// (R9) stop-seen bit set by stop, cleared by reset or disable
// (R10) start-seen bit set by start, cleared by reset or disable
// (R11) data-or-address bit tracks kind of last byte
// (R12) slave: direction bit holds read/write of last matched address
// (R13) master: direction bit shows transmit in progress, idle by or
// (R14) ten-bit mode: update-address bit asks software for next address
// (R15) receive: buffer-full set on byte in, clear when empty
// (R16) i2c transmit: buffer-full set while data bits shift out
// (R17) buffer write during transmit sets write collision, software clears
// (R18) i2c receive into full buffer sets overflow, ignored on transmit
// (R19) enable bit gives pins to port, clear returns them to i/o
// (R20) slave: clock-release bit low stretches clock, high releases; code stretches only in modes with mode bit 3 clear
// (R21) four-bit mode field selects slave, master, firmware, spi modes
// (R22) i2c: sample bit disables slew, edge bit selects smbus levels
// (R23) master collision sets flag, idles port, clears condition bit
// (R24) one generator period after stop-seen, clear stop request, irq
//
// Our own choices: the address map and the strobed register port.
`default_nettype none
module spbs_core (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            pins_owned_o,
    output logic            slew_off_o,
    output logic            smbus_levels_o,
    output logic [3:0]      mode_o,
    // events from the shifter and address logic outside
    input  wire logic       start_seen_i,
    input  wire logic       byte_rx_i,
    input  wire logic       byte_is_data_i,
    input  wire logic       addr_match_i,
    input  wire logic       addr_rw_i,
    input  wire logic       nack_i,
    input  wire logic       update_addr_i,
    input  wire logic       tx_done_i,
    input  wire logic       op_done_i,
    input  wire logic       other_bcol_i,
    output logic            buf_written_o,
    output logic [7:0]      tx_data_o,
    output logic            brg_tick_o
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [7:0] status;
        logic [7:0] ctrl1;
        logic [4:0] ctrl2;
        logic [1:0] events;
        logic [7:0] reload;
        logic [7:0] rxbuf;
        logic [7:0] txbuf;
        logic [7:0] baud_generator;
        logic       brg_run;
        logic       scl_lvl;
        logic       sda_drv_low;
        spbs_pkg::spbs_stop_t st;
        logic [7:0] rdata;
        logic       tick;
        logic       wr_pulse;
        logic       pre;
    } spbs_state_t;

    spbs_state_t q;
    spbs_state_t n;

    function automatic logic is_i2c_master(input logic [3:0] m);
        return m == spbs_pkg::MODE_I2C_MASTER || m == spbs_pkg::MODE_I2C_FW;
    endfunction

    function automatic logic is_master(input logic [3:0] m);
        return is_i2c_master(m) || m == spbs_pkg::MODE_SPI_MASTER
            || m[3:2] == 2'b00;
    endfunction

    logic       scl_in;
    logic       sda_in;
    logic       en;
    logic       mst;
    logic       i2c_mst;
    logic       expired;
    logic       busy;
    logic       buf_wr;

    assign scl_in  = q.scl_s[1];
    assign sda_in  = q.sda_s[1];
    assign en      = q.ctrl1[spbs_pkg::C1_EN];
    assign mst     = is_master(q.ctrl1[3:0]);
    assign i2c_mst = is_i2c_master(q.ctrl1[3:0]);
    assign expired = q.brg_run && q.pre && q.baud_generator == 8'h00;
    assign busy    = q.status[spbs_pkg::ST_FULL] || q.st != spbs_pkg::SPBS_IDLE;
    assign buf_wr  = wr_i && addr_i == spbs_pkg::ADDR_BUFFER;

    always_comb begin
        n = q;
        n.scl_s = {q.scl_s[0], scl_i};
        n.sda_s = {q.sda_s[0], sda_i};
        n.tick = 1'b0;
        n.wr_pulse = 1'b0;
        n.rdata = spbs_pkg::READ_UNMAPPED;
        // generator: counts down, reloads at zero (two rollovers per period)
        // (R7) half-rate count, rollover every 2*(reload+1) clocks
        n.pre = q.brg_run && !q.pre;
        // (R6) reload at rollover
        if (q.brg_run) begin
            if (q.pre && q.baud_generator == 8'h00) begin
                n.baud_generator = q.reload;
                n.tick = 1'b1;
                // (R7) half period toggles clock
                if (i2c_mst && q.st == spbs_pkg::SPBS_IDLE) begin
                    n.scl_lvl = ~q.scl_lvl;
                end
            end else if (q.pre) begin
                n.baud_generator = q.baud_generator - 8'h01;
            end
        end
        // (R5) stop counting, clock level kept
        if (op_done_i) begin
            n.brg_run = 1'b0;
        end
        // software writes
        if (wr_i) begin
            unique case (addr_i)
                spbs_pkg::ADDR_STATUS: begin
                    // (R22) only sample and edge bits writable
                    n.status[7:6] = wdata_i[7:6];
                end
                spbs_pkg::ADDR_CTRL1: begin
                    // (R17) software clears write collision
                    n.ctrl1 = wdata_i;
                end
                spbs_pkg::ADDR_RELOAD: n.reload = wdata_i;
                spbs_pkg::ADDR_CTRL2: begin
                    // requests accepted only while idle
                    if (!busy && q.ctrl2 == 5'h00) begin
                        n.ctrl2 = wdata_i[4:0];
                    end
                end
                spbs_pkg::ADDR_EVENTS: n.events = q.events & ~wdata_i[1:0];
                spbs_pkg::ADDR_BUFFER: begin
                    if (busy) begin
                        // (R17) write lost, flag raised
                        n.ctrl1[spbs_pkg::C1_WRITE_COLLISION_FLAG] = 1'b1;
                    end else begin
                        n.txbuf = wdata_i;
                        n.wr_pulse = 1'b1;
                        // (R16) full while shifting out
                        n.status[spbs_pkg::ST_FULL] = i2c_mst;
                        // (R4) generator starts on buffer write
                        if (mst) begin
                            n.baud_generator = q.reload;
                            n.brg_run = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                spbs_pkg::ADDR_STATUS: n.rdata = q.status;
                spbs_pkg::ADDR_CTRL1:  n.rdata = q.ctrl1;
                spbs_pkg::ADDR_RELOAD: n.rdata = q.reload;
                spbs_pkg::ADDR_BUFFER: begin
                    n.rdata = q.rxbuf;
                    // (R15) reading empties the buffer
                    n.status[spbs_pkg::ST_FULL] = 1'b0;
                end
                spbs_pkg::ADDR_CTRL2:  n.rdata = {3'h0, q.ctrl2};
                spbs_pkg::ADDR_EVENTS: n.rdata = {6'h00, q.events};
                default: n.rdata = spbs_pkg::READ_UNMAPPED;
            endcase
        end
        // (R16) transmit complete empties buffer
        if (tx_done_i) begin
            n.status[spbs_pkg::ST_FULL] = 1'b0;
            n.status[spbs_pkg::ST_DIR] = 1'b0;
        end
        // (R13) master direction shows transmit in progress
        if (q.wr_pulse && i2c_mst) begin
            n.status[spbs_pkg::ST_DIR] = 1'b1;
        end
        // (R15) byte received; (R18) overflow if still full
        if (byte_rx_i) begin
            if (q.status[spbs_pkg::ST_FULL] && !q.status[spbs_pkg::ST_DIR]) begin
                n.ctrl1[spbs_pkg::C1_OVF] = 1'b1;
            end else begin
                n.status[spbs_pkg::ST_FULL] = 1'b1;
            end
        end
        // (R11) data or address
        if (byte_rx_i || tx_done_i) begin
            n.status[spbs_pkg::ST_DATA] = byte_is_data_i;
        end
        // (R12) slave direction latch, dropped at start or nack
        if (!mst && addr_match_i) begin
            n.status[spbs_pkg::ST_DIR] = addr_rw_i;
        end else if (!mst && (start_seen_i || nack_i)) begin
            n.status[spbs_pkg::ST_DIR] = 1'b0;
        end
        // (R14) ten-bit address update request
        if (update_addr_i && q.ctrl1[2:0] == 3'b111) begin
            n.status[spbs_pkg::ST_UPDATE] = 1'b1;
        end else if (wr_i && addr_i == spbs_pkg::ADDR_RELOAD) begin
            n.status[spbs_pkg::ST_UPDATE] = 1'b0;
        end
        // (R10) start seen last
        if (start_seen_i) begin
            n.status[spbs_pkg::ST_START] = 1'b1;
            n.status[spbs_pkg::ST_STOP] = 1'b0;
        end
        // stop sequence
        unique case (q.st)
            spbs_pkg::SPBS_IDLE: begin
                if (q.ctrl2[spbs_pkg::C2_STOP] && i2c_mst) begin
                    // (R3) begin with data low
                    n.sda_drv_low = 1'b1;
                    n.scl_lvl = 1'b0;
                    n.st = spbs_pkg::SPBS_SDA_LOW;
                end
            end
            spbs_pkg::SPBS_SDA_LOW: begin
                if (!sda_in) begin
                    n.scl_lvl = 1'b1;
                    n.st = spbs_pkg::SPBS_SCL_REL;
                end
            end
            spbs_pkg::SPBS_SCL_REL: begin
                if (scl_in) begin
                    // (R3) load generator from reload register
                    n.baud_generator = q.reload;
                    n.brg_run = 1'b1;
                    n.st = spbs_pkg::SPBS_SCL_HIGH;
                end
            end
            spbs_pkg::SPBS_SCL_HIGH: begin
                // (R2) clock pulled low before data released
                if (!scl_in) begin
                    n.events[spbs_pkg::EV_BCOL] = 1'b1;
                    n.st = spbs_pkg::SPBS_IDLE;
                end else if (expired) begin
                    n.sda_drv_low = 1'b0;
                    n.baud_generator = q.reload;
                    n.st = spbs_pkg::SPBS_SDA_REL;
                end
            end
            spbs_pkg::SPBS_SDA_REL: begin
                if (!scl_in) begin
                    // (R2) clock low before data high
                    n.events[spbs_pkg::EV_BCOL] = 1'b1;
                    n.st = spbs_pkg::SPBS_IDLE;
                end else if (expired) begin
                    if (!sda_in) begin
                        // (R1) data held low by another master
                        n.events[spbs_pkg::EV_BCOL] = 1'b1;
                        n.st = spbs_pkg::SPBS_IDLE;
                    end else begin
                        // (R9) stop seen
                        n.status[spbs_pkg::ST_STOP] = 1'b1;
                        n.status[spbs_pkg::ST_START] = 1'b0;
                        n.baud_generator = q.reload;
                        n.st = spbs_pkg::SPBS_DONE;
                    end
                end
            end
            spbs_pkg::SPBS_DONE: begin
                // (R24) one period later finish
                if (expired) begin
                    n.ctrl2[spbs_pkg::C2_STOP] = 1'b0;
                    n.events[spbs_pkg::EV_PIRQ] = 1'b1;
                    n.brg_run = 1'b0;
                    n.st = spbs_pkg::SPBS_IDLE;
                end
            end
            default: n.st = spbs_pkg::SPBS_IDLE;
        endcase
        // (R23) any collision: abort, release lines, idle
        if (other_bcol_i || q.st inside {spbs_pkg::SPBS_SCL_HIGH,
                spbs_pkg::SPBS_SDA_REL} && n.st == spbs_pkg::SPBS_IDLE) begin
            n.events[spbs_pkg::EV_BCOL] = 1'b1;
            n.ctrl2 = 5'h00;
            n.sda_drv_low = 1'b0;
            n.scl_lvl = 1'b1;
            n.brg_run = 1'b0;
            n.status[spbs_pkg::ST_FULL] = 1'b0;
            n.status[spbs_pkg::ST_DIR] = 1'b0;
            n.st = spbs_pkg::SPBS_IDLE;
        end
        // (R9) (R10) disable clears start and stop seen
        if (!n.ctrl1[spbs_pkg::C1_EN]) begin
            n.status[spbs_pkg::ST_STOP] = 1'b0;
            n.status[spbs_pkg::ST_START] = 1'b0;
            n.ctrl2 = 5'h00;
            n.brg_run = 1'b0;
            n.sda_drv_low = 1'b0;
            n.scl_lvl = 1'b1;
            n.st = spbs_pkg::SPBS_IDLE;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{scl_s: 2'b11, sda_s: 2'b11,
                   status: spbs_pkg::STATUS_RESET,
                   ctrl1: spbs_pkg::CTRL1_RESET, ctrl2: 5'h00,
                   events: 2'b00, reload: spbs_pkg::RELOAD_RESET,
                   rxbuf: 8'h00, txbuf: 8'h00, baud_generator: 8'h00,
                   brg_run: 1'b0, scl_lvl: 1'b1, sda_drv_low: 1'b0,
                   st: spbs_pkg::SPBS_IDLE, rdata: 8'h00,
                   tick: 1'b0, wr_pulse: 1'b0, pre: 1'b0};
        end else begin
            q <= n;
        end
    end

    // (R19) pins owned only while enabled; open drain drive
    assign pins_owned_o  = en;
    assign scl_o         = 1'b0;
    // (R20) slave stretch while release bit clear, only in modes with mode bit 3 clear
    assign scl_oe_o      = en && (i2c_mst ? !q.scl_lvl
                                   : !q.ctrl1[spbs_pkg::C1_CKREL]
                                     && !q.ctrl1[3]);
    assign sda_o         = 1'b0;
    assign sda_oe_o      = en && q.sda_drv_low;
    // (R22) i2c pad controls
    assign slew_off_o     = q.status[spbs_pkg::ST_SAMPLE];
    assign smbus_levels_o = q.status[spbs_pkg::ST_EDGE];
    // (R21) mode field to the rest of the port
    assign mode_o        = q.ctrl1[3:0];
    assign rdata_o       = q.rdata;
    assign buf_written_o = q.wr_pulse;
    assign tx_data_o     = q.txbuf;
    assign brg_tick_o    = q.tick;

    // (R1) collision flagged when data low at expiry
    a_stop_data_low: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.st == spbs_pkg::SPBS_SDA_REL && expired && scl_in && !sda_in && en
        |=> q.events[spbs_pkg::EV_BCOL] && q.st == spbs_pkg::SPBS_IDLE)
        else $error("stop data low not flagged");
    // (R2) clock low during stop flags collision
    a_stop_clk_low: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.st == spbs_pkg::SPBS_SCL_HIGH && !scl_in && en
        |=> q.events[spbs_pkg::EV_BCOL])
        else $error("stop clock low not flagged");
    // (R3) generator loaded when clock seen high
    a_stop_load: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.st == spbs_pkg::SPBS_SCL_REL && scl_in && en && !other_bcol_i
        |=> q.baud_generator == $past(q.reload) && q.brg_run)
        else $error("generator not loaded in stop");
    // (R4) buffer write starts generator
    a_buf_starts_brg: assert property (@(posedge mclk_i) disable iff (rst_i)
        buf_wr && !busy && mst && en && !other_bcol_i && !op_done_i
        |=> q.brg_run && q.wr_pulse)
        else $error("buffer write did not start generator");
    // (R17) write during transmit sets collision
    a_write_collision_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i)
        buf_wr && busy |=> q.ctrl1[spbs_pkg::C1_WRITE_COLLISION_FLAG] && $stable(q.txbuf))
        else $error("write collision missed");
    // (R9) stop seen cleared when disabled
    a_stop_seen_clr: assert property (@(posedge mclk_i) disable iff (rst_i)
        !en |-> !q.status[spbs_pkg::ST_STOP] && !q.status[spbs_pkg::ST_START])
        else $error("start or stop seen while disabled");
    // (R24) stop request cleared with port irq
    a_stop_finish: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(q.ctrl2[spbs_pkg::C2_STOP]) && en && !q.events[1]
        |-> q.events[spbs_pkg::EV_PIRQ] && q.status[spbs_pkg::ST_STOP])
        else $error("stop finished without irq");
    // (R19) no drive while disabled
    a_pins_free: assert property (@(posedge mclk_i) disable iff (rst_i)
        !en |-> !scl_oe_o && !sda_oe_o)
        else $error("pins driven while disabled");
    // (R18) overflow on receive into full buffer
    a_rx_overflow: assert property (@(posedge mclk_i) disable iff (rst_i)
        byte_rx_i && q.status[spbs_pkg::ST_FULL] && !q.status[2]
        && !(wr_i && addr_i == spbs_pkg::ADDR_CTRL1)
        |=> q.ctrl1[spbs_pkg::C1_OVF])
        else $error("overflow not flagged");
endmodule
`default_nettype wire

/* File: spbs_bus_model.sv */
// far-side peer on the open-drain bus: pull-ups, stretching, collisions
`default_nettype none
module spbs_bus_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       scl_oe_i,
    input  wire logic       sda_oe_i,
    input  wire logic       hold_sda_i,
    input  wire logic       grab_scl_i,
    input  wire logic [3:0] stretch_i,
    output logic            scl_o,
    output logic            sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // slow peer keeps clock low a while after the port lets it go
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            cnt <= 4'h0;
        else if (scl_oe_i)
            cnt <= stretch_i;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
    // released lines float to the pull-up level, never hold old values
    assign scl_o = !(scl_oe_i || grab_scl_i || cnt != 4'h0);
    assign sda_o = !(sda_oe_i || hold_sda_i);
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the serial port stop/baud/status block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [1:0] lv = 2'h0;
    logic       hold_sda = 1'b0;
    logic       grab_scl = 1'b0;
    logic [3:0] stretch = 4'h0;
    logic       scl, sda, scl_oe, sda_oe, owned, slew, smb, tick, bw;
    logic [7:0] rdata, txd, v, rl, d, x;
    logic [3:0] mode;
    int         err_count = 0;
    int         total_checks = 0;
    int         nt = 0, nbw = 0, since = 0, gap = 0, k;

    spbs_core DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe_o(scl_oe),
        .sda_o(), .sda_oe_o(sda_oe), .pins_owned_o(owned),
        .slew_off_o(slew), .smbus_levels_o(smb), .mode_o(mode),
        .start_seen_i(ev[0]), .byte_rx_i(ev[1]), .byte_is_data_i(lv[1]),
        .addr_match_i(ev[2]), .addr_rw_i(lv[0]), .nack_i(ev[3]),
        .update_addr_i(ev[4]), .tx_done_i(ev[5]), .op_done_i(ev[6]),
        .other_bcol_i(ev[7]), .buf_written_o(bw), .tx_data_o(txd),
        .brg_tick_o(tick)
    );
    spbs_bus_model peer (
        .mclk_i(mclk_i), .rst_i(rst_i), .scl_oe_i(scl_oe),
        .sda_oe_i(sda_oe), .hold_sda_i(hold_sda), .grab_scl_i(grab_scl),
        .stretch_i(stretch), .scl_o(scl), .sda_o(sda)
    );

    always #4 mclk_i = ~mclk_i;
    // gap holds the edges between the last two generator rollovers
    always @(posedge mclk_i) begin
        since <= tick ? 1 : since + 1;
        if (tick) gap <= since;
        nt  <= nt + int'(tick);
        nbw <= nbw + int'(bw);
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tmo(input bit ok);
        if (!ok) begin
            err_count++;
            $display("[FAIL] wait expected done seen timeout");
            stop_test();
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] dt);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= dt;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] m, e);
        rd(a);
        chk($sformatf("reg %0d", a), e, v & m);
    endtask
    task automatic pulse(input int i, input logic [1:0] l);
        @(posedge mclk_i);
        ev[i] <= 1'b1;
        lv    <= l;
        @(posedge mclk_i);
        ev    <= 8'h00;
    endtask
    task automatic poll(input logic [2:0] a, input logic [7:0] m);
        int i;
        v = 8'h00;
        for (i = 0; i < 200 && (v & m) == 8'h00; i++) rd(a);
        tmo((v & m) != 8'h00);
    endtask
    // c: 0 clean stop, 1 peer holds data low, 2 peer pulls clock low
    task automatic stop_seq(input int c, input logic [3:0] s);
        int i;
        logic [7:0] e;
        @(posedge mclk_i);
        hold_sda <= (c == 1);
        stretch  <= s;
        wr(spbs_pkg::ADDR_CTRL2, 8'h04);
        for (i = 0; i < 50 && sda_oe !== 1'b1; i++) @(negedge mclk_i);
        tmo(i < 50);
        chk("clock held", 8'h01, {7'h0, scl_oe});
        for (i = 0; i < 50 && scl_oe !== 1'b0; i++) @(negedge mclk_i);
        tmo(i < 50);
        chk("data held", 8'h01, {7'h0, sda_oe});
        if (c == 2) begin
            repeat (3) @(posedge mclk_i);
            grab_scl <= 1'b1;
        end
        e = (c == 0) ? 8'h01 : 8'h02;
        poll(spbs_pkg::ADDR_EVENTS, e);
        rchk(spbs_pkg::ADDR_EVENTS, 8'h03, e);
        rchk(spbs_pkg::ADDR_CTRL2, 8'h04, 8'h00);
        chk("lines free", 8'h00, {6'h0, scl_oe, sda_oe});
        if (c == 0) rchk(spbs_pkg::ADDR_STATUS, 8'h18, 8'h10);
        @(posedge mclk_i);
        hold_sda <= 1'b0;
        grab_scl <= 1'b0;
        wr(spbs_pkg::ADDR_EVENTS, 8'h03);
    endtask

    initial begin
        void'($urandom(32'hAA093EB6));
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        rchk(spbs_pkg::ADDR_STATUS, 8'hFF, spbs_pkg::STATUS_RESET);
        rchk(spbs_pkg::ADDR_CTRL1, 8'hFF, spbs_pkg::CTRL1_RESET);
        rchk(spbs_pkg::ADDR_RELOAD, 8'hFF, spbs_pkg::RELOAD_RESET);
        rchk(3'h6, 8'hFF, spbs_pkg::READ_UNMAPPED);
        for (int m = 0; m < 16; m++) begin
            x = 8'h30 | 8'(m);
            d = 8'($urandom);
            wr(spbs_pkg::ADDR_CTRL1, x);
            wr(spbs_pkg::ADDR_STATUS, d);
            rchk(spbs_pkg::ADDR_CTRL1, 8'h3F, x);
            chk("mode", x & 8'h0F, {4'h0, mode});
            chk("owned", 8'h01, {7'h0, owned});
            rchk(spbs_pkg::ADDR_STATUS, 8'hFF, d & 8'hC0);
            chk("levels", {6'h0, d[7:6]}, {6'h0, slew, smb});
        end
        rl = 8'h03 + 8'($urandom % 8);
        wr(spbs_pkg::ADDR_CTRL1, 8'h28);
        wr(spbs_pkg::ADDR_RELOAD, rl);
        rchk(spbs_pkg::ADDR_RELOAD, 8'hFF, rl);
        stop_seq(1, 4'h0);
        stop_seq(2, 4'h0);
        stop_seq(0, 4'(1 + $urandom % 8));
        stop_seq(0, 4'h0);
        wr(spbs_pkg::ADDR_CTRL1, 8'h08);
        rchk(spbs_pkg::ADDR_STATUS, 8'h18, 8'h00);
        chk("owned", 8'h00, {7'h0, owned});
        wr(spbs_pkg::ADDR_CTRL1, 8'h36);
        pulse(0, 2'b00);
        rchk(spbs_pkg::ADDR_STATUS, 8'h18, 8'h08);
        pulse(1, 2'b10);
        rchk(spbs_pkg::ADDR_STATUS, 8'h21, 8'h21);
        pulse(1, 2'b10);
        rchk(spbs_pkg::ADDR_CTRL1, 8'h40, 8'h40);
        rd(spbs_pkg::ADDR_BUFFER);
        rchk(spbs_pkg::ADDR_STATUS, 8'h01, 8'h00);
        pulse(1, 2'b00);
        rchk(spbs_pkg::ADDR_STATUS, 8'h20, 8'h00);
        rd(spbs_pkg::ADDR_BUFFER);
        pulse(2, 2'b01);
        rchk(spbs_pkg::ADDR_STATUS, 8'h04, 8'h04);
        pulse(3, 2'b00);
        rchk(spbs_pkg::ADDR_STATUS, 8'h04, 8'h00);
        pulse(4, 2'b00);
        rchk(spbs_pkg::ADDR_STATUS, 8'h02, 8'h00);
        wr(spbs_pkg::ADDR_CTRL1, 8'h37);
        pulse(4, 2'b00);
        rchk(spbs_pkg::ADDR_STATUS, 8'h02, 8'h02);
        wr(spbs_pkg::ADDR_RELOAD, rl);
        rchk(spbs_pkg::ADDR_STATUS, 8'h02, 8'h00);
        wr(spbs_pkg::ADDR_CTRL1, 8'h26);
        repeat (2) @(negedge mclk_i);
        chk("stretch", 8'h01, {7'h0, scl_oe});
        wr(spbs_pkg::ADDR_CTRL1, 8'h36);
        repeat (2) @(negedge mclk_i);
        chk("release", 8'h00, {7'h0, scl_oe});
        pulse(7, 2'b00);
        rchk(spbs_pkg::ADDR_EVENTS, 8'h02, 8'h02);
        wr(spbs_pkg::ADDR_EVENTS, 8'h03);
        wr(spbs_pkg::ADDR_CTRL1, 8'h28);
        d = 8'($urandom);
        k = nbw;
        wr(spbs_pkg::ADDR_BUFFER, d);
        x = 8'(nt);
        for (int i = 0; i < 400 && 8'(nt) < x + 8'h02; i++)
            @(negedge mclk_i);
        tmo(8'(nt) >= x + 8'h02);
        chk("period", 8'h02 * (rl + 8'h01), 8'(gap));
        chk("tx data", d, txd);
        rchk(spbs_pkg::ADDR_STATUS, 8'h05, 8'h05);
        // a second write while shifting must be dropped, not queued
        wr(spbs_pkg::ADDR_BUFFER, ~d);
        rchk(spbs_pkg::ADDR_CTRL1, 8'h80, 8'h80);
        chk("tx kept", d, txd);
        chk("accepted", 8'(k + 1), 8'(nbw));
        wr(spbs_pkg::ADDR_CTRL1, 8'h28);
        rchk(spbs_pkg::ADDR_CTRL1, 8'h80, 8'h00);
        pulse(5, 2'b00);
        rchk(spbs_pkg::ADDR_STATUS, 8'h01, 8'h00);
        pulse(6, 2'b00);
        repeat (4) @(posedge mclk_i);
        k = nt;
        x = {7'h0, scl_oe};
        repeat (40) @(posedge mclk_i);
        chk("stopped", 8'(k), 8'(nt));
        chk("clock kept", x, {7'h0, scl_oe});
        stop_test();
    end
endmodule
`default_nettype wire
